// >>> rtl/capture_channel_regs.vh
// constants for the input-capture timer channel: offsets, fields, encodings, reset values
// assumes the includer uses these as 32-bit register-bus byte addresses and field codes
`ifndef CAPTURE_CHANNEL_REGS_VH
`define CAPTURE_CHANNEL_REGS_VH

// register offsets (byte addresses, word aligned)
`define OFS_CLK_CTRL      8'h00
`define OFS_CAP_CTRL      8'h04
`define OFS_STATUS        8'h08
`define OFS_COUNTER       8'h0C
`define OFS_CAP_A         8'h10
`define OFS_CAP_B         8'h14
`define OFS_CAP_C         8'h18
`define OFS_CAP_D         8'h1C
`define OFS_FILT_CTRL     8'h20

// count source codes
`define SRC_EXT_A         3'h0
`define SRC_EXT_B         3'h1
`define SRC_EXT_C         3'h2
`define SRC_EXT_D         3'h3
`define SRC_CASCADE       3'h4
`define SRC_INTERNAL      3'h5

// edge codes, shared by count clock and capture inputs
`define EDGE_RISE         2'h0
`define EDGE_FALL         2'h1
`define EDGE_BOTH         2'h2

// clear source codes
`define CLR_CAP_A         3'h0
`define CLR_CAP_B         3'h1
`define CLR_CAP_C         3'h2
`define CLR_CAP_D         3'h3
`define CLR_SYNC          3'h4
`define CLR_NONE          3'h5

// clock control fields
`define CC_SRC_LSB        0
`define CC_EDGE_LSB       4
`define CC_DIV_LSB        8
`define CC_CLR_LSB        12
`define CC_RUN_BIT        16
`define CC_ADC_BIT        17

// capture control: per register x, field base is 8*x
`define CP_EN_BIT         0
`define CP_IRQ_BIT        1
`define CP_REP_BIT        2
`define CP_FILT_BIT       3
`define CP_EDGE_LSB       4

// reset values
`define CLK_CTRL_RST      32'h0000_0055
`define CAP_CTRL_RST      32'h0000_0000
`define FILT_CTRL_RST     16'h0003

`endif

// >>> rtl/timer_input_capture_channel.v
// one timer channel in input-capture mode with count source, prescaler, clear and filter
// assumes synchronous pins, a single-cycle register port, and a channel number fixed by parameter
//
// Contract
// [R1] count clock from ext pins A-D, cascade or divided peripheral clock
// [R2] ext pin C only on channels 0 and 2, pin D only on 0
// [R3] cascade counts channel 2 overflow/underflow, offered only on channel 1
// [R4] counter advances on rising, falling or both edges of count clock; code applies the edge select to external pin sources only
// [R5] undivided peripheral clock or cascade ignore edge selection, count rising
// [R6] prescaler divides by 1,2,4,8,16,32,64,256 or 1024
// [R7] prescaler setting has no effect with an external pin source
// [R8] clear by capture A-D, synchronous clear, or never
// [R9] clear on capture C/D only on channels 0,3,4,6,7,8
// [R10] synchronous clear follows other channels' common clear
// [R11] registers A-D capture from own pin on channels 0-4 and 6-8
// [R12] capture happens only when enabled for that register
// [R13] each capture register raises an interrupt request when enabled
// [R14] register A match starts A/D on channels 0-4, 6, 7
// [R15] without repeat, counting stops after first capture is serviced; code stops only if that register's interrupt is enabled
// [R16] capture input triggers on rising, falling or both edges
// [R17] each capture pin has an individually bypassable noise filter
// [R18] filter sampling clock is a separate setting made beforehand
// [R19] capture loads counter; clear source capture then zeroes counter
`timescale 1ns/1ps
`include "capture_channel_regs.vh"

module timer_input_capture_channel #(
    parameter CHANNEL = 0
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rdata,
    input  wire        ext_count_clock_a,
    input  wire        ext_count_clock_b,
    input  wire        ext_count_clock_c,
    input  wire        ext_count_clock_d,
    input  wire        cascade_ovf,
    input  wire        cascade_unf,
    input  wire        sync_clear_in,
    input  wire [3:0]  capture_input_pin,
    output wire [3:0]  capture_irq,
    output reg         adc_trigger,
    output wire        overflow,
    output wire        underflow,
    output wire        clear_out
);

    localparam HAS_C   = (CHANNEL == 0) || (CHANNEL == 2);
    localparam HAS_D   = (CHANNEL == 0);
    localparam HAS_CAS = (CHANNEL == 1);
    localparam CLR_CD  = (CHANNEL == 0) || (CHANNEL == 3) || (CHANNEL == 4) ||
                         (CHANNEL >= 6 && CHANNEL <= 8);
    localparam HAS_CAP = (CHANNEL <= 4) || (CHANNEL >= 6 && CHANNEL <= 8);
    localparam HAS_ADC = (CHANNEL <= 4) || (CHANNEL == 6) || (CHANNEL == 7);

    reg  [31:0] clk_ctrl_r;
    reg  [31:0] cap_ctrl_r;
    reg  [15:0] filt_ctrl_r;
    reg  [15:0] channel_counter_r;
    wire [15:0] cap_val [0:3];
    wire [3:0]  cap_flag;
    wire [3:0]  stop_pend;
    reg  [9:0]  presc_r;
    reg         cnt_in_r;
    reg  [15:0] filt_div_r;
    reg  [3:0]  cap_prev_r;

    wire [2:0]  src      = clk_ctrl_r[`CC_SRC_LSB +: 3];
    wire [1:0]  cedge    = clk_ctrl_r[`CC_EDGE_LSB +: 2];
    wire [3:0]  div_sel  = clk_ctrl_r[`CC_DIV_LSB +: 4];
    wire [2:0]  clr_sel  = clk_ctrl_r[`CC_CLR_LSB +: 3];
    wire        run      = clk_ctrl_r[`CC_RUN_BIT];

    // divided peripheral clock tick
    reg         presc_tick;
    always @* begin
        case (div_sel)
            4'h0:    presc_tick = 1'b1;
            4'h1:    presc_tick = (presc_r[0] == 1'b1);
            4'h2:    presc_tick = (presc_r[1:0] == 2'h3);
            4'h3:    presc_tick = (presc_r[2:0] == 3'h7);
            4'h4:    presc_tick = (presc_r[3:0] == 4'hF);
            4'h5:    presc_tick = (presc_r[4:0] == 5'h1F);
            4'h6:    presc_tick = (presc_r[5:0] == 6'h3F);
            4'h7:    presc_tick = (presc_r[7:0] == 8'hFF);
            4'h8:    presc_tick = (presc_r == 10'h3FF);
            default: presc_tick = 1'b1;
        endcase
    end

    // selected external level, gated by channel availability
    reg ext_lvl;
    reg ext_sel;
    always @* begin
        ext_lvl = 1'b0;
        ext_sel = 1'b0;
        case (src)
            `SRC_EXT_A: begin
                ext_lvl = ext_count_clock_a;
                ext_sel = 1'b1;
            end
            `SRC_EXT_B: begin
                ext_lvl = ext_count_clock_b;
                ext_sel = 1'b1;
            end
            // [R2] pin C limit
            `SRC_EXT_C: begin
                ext_lvl = ext_count_clock_c & HAS_C;
                ext_sel = HAS_C;
            end
            // [R2] pin D limit
            `SRC_EXT_D: begin
                ext_lvl = ext_count_clock_d & HAS_D;
                ext_sel = HAS_D;
            end
            default: begin
                ext_lvl = 1'b0;
                ext_sel = 1'b0;
            end
        endcase
    end

    // count tick per source and edge
    reg tick;
    always @* begin
        tick = 1'b0;
        if (ext_sel) begin
            // [R4] edge select on pins
            case (cedge)
                `EDGE_RISE: tick = ext_lvl & ~cnt_in_r;
                `EDGE_FALL: tick = ~ext_lvl & cnt_in_r;
                default:    tick = ext_lvl ^ cnt_in_r;
            endcase
        end else if (src == `SRC_CASCADE) begin
            // [R3] [R5] cascade counts rising only
            tick = HAS_CAS & (cascade_ovf | cascade_unf);
        end else if (src == `SRC_INTERNAL) begin
            // [R6] [R7] prescaler only for internal
            tick = presc_tick;
        end
    end

    // [R18] filter sampling period set apart from the filter enables
    wire filt_sample = (filt_div_r == filt_ctrl_r);

    // software services a capture by writing one to its status bit
    wire status_wr = wr_en && (addr == `OFS_STATUS);
    wire run_wr    = wr_en && (addr == `OFS_CLK_CTRL) && wdata[`CC_RUN_BIT];

    wire [3:0] pin_eff;
    wire [3:0] cap_ev;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ch
            reg [2:0] hist_r;
            reg       filt_r;
            wire [1:0] e = cap_ctrl_r[8*g + `CP_EDGE_LSB +: 2];
            always @(posedge clk) begin
                if (!reset_n) begin
                    hist_r <= 3'h0;
                    filt_r <= 1'b0;
                end else if (filt_sample) begin
                    hist_r <= {hist_r[1:0], capture_input_pin[g]};
                    // [R17] three equal samples
                    if (hist_r == 3'h7)
                        filt_r <= 1'b1;
                    else if (hist_r == 3'h0)
                        filt_r <= 1'b0;
                end
            end
            // [R17] per-pin bypass
            assign pin_eff[g] = cap_ctrl_r[8*g + `CP_FILT_BIT] ? filt_r
                                                              : capture_input_pin[g];
            // [R16] [R11] [R12] edge, availability, enable
            assign cap_ev[g] = HAS_CAP && cap_ctrl_r[8*g + `CP_EN_BIT] &&
                               ((e == `EDGE_RISE) ? (pin_eff[g] & ~cap_prev_r[g]) :
                                (e == `EDGE_FALL) ? (~pin_eff[g] & cap_prev_r[g]) :
                                (pin_eff[g] ^ cap_prev_r[g]));
            // [R13] capture interrupt request
            assign capture_irq[g] = cap_flag[g] & cap_ctrl_r[8*g + `CP_IRQ_BIT];
            reg [15:0] cap_val_r;
            reg        flag_r;
            reg        stop_r;
            wire       svc = status_wr && wdata[g];
            // [R19] capture loads the counter value before any clear
            always @(posedge clk) begin
                if (!reset_n) begin
                    cap_val_r <= 16'h0000;
                end else if (cap_ev[g]) begin
                    cap_val_r <= channel_counter_r;
                end
            end
            // sticky flag, write one to clear; set wins over a same-cycle clear
            always @(posedge clk) begin
                if (!reset_n) begin
                    flag_r <= 1'b0;
                end else if (cap_ev[g]) begin
                    flag_r <= 1'b1;
                end else if (svc) begin
                    flag_r <= 1'b0;
                end
            end
            // [R15] without repeat, servicing an enabled flag stops the count
            always @(posedge clk) begin
                if (!reset_n) begin
                    stop_r <= 1'b0;
                end else if (run_wr) begin
                    stop_r <= 1'b0;
                end else if (svc && flag_r && cap_ctrl_r[8*g + `CP_IRQ_BIT] &&
                             !cap_ctrl_r[8*g + `CP_REP_BIT]) begin
                    stop_r <= 1'b1;
                end
            end
            assign cap_val[g]   = cap_val_r;
            assign cap_flag[g]  = flag_r;
            assign stop_pend[g] = stop_r;
        end
    endgenerate

    // clear selection
    reg clr_hit;
    always @* begin
        case (clr_sel)
            // [R8] clear on capture A/B
            `CLR_CAP_A: clr_hit = cap_ev[0];
            `CLR_CAP_B: clr_hit = cap_ev[1];
            // [R9] C/D clear limit
            `CLR_CAP_C: clr_hit = cap_ev[2] & CLR_CD;
            `CLR_CAP_D: clr_hit = cap_ev[3] & CLR_CD;
            // [R10] synchronous clear
            `CLR_SYNC:  clr_hit = sync_clear_in;
            default:    clr_hit = 1'b0;
        endcase
    end

    // a pending stop from any register halts the count until run is rewritten
    wire counting = run && (stop_pend == 4'h0);
    assign overflow   = counting & tick & (channel_counter_r == 16'hFFFF);
    // up counter only, so it never wraps downwards
    assign underflow  = 1'b0;
    assign clear_out  = clr_hit & (clr_sel != `CLR_SYNC);

    wire [31:0] status_word = {23'h00_0000, counting, stop_pend, cap_flag};

    // control registers written by software
    always @(posedge clk) begin
        if (!reset_n) begin
            clk_ctrl_r  <= `CLK_CTRL_RST;
            cap_ctrl_r  <= `CAP_CTRL_RST;
            filt_ctrl_r <= `FILT_CTRL_RST;
        end else if (wr_en) begin
            case (addr)
                `OFS_CLK_CTRL: begin
                    clk_ctrl_r <= wdata;
                end
                `OFS_CAP_CTRL: begin
                    cap_ctrl_r <= wdata;
                end
                `OFS_FILT_CTRL: begin
                    filt_ctrl_r <= wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // free-running prescaler
    always @(posedge clk) begin
        if (!reset_n) begin
            presc_r <= 10'h000;
        end else begin
            presc_r <= presc_r + 10'h001;
        end
    end

    // previous levels for count and capture edge detection
    always @(posedge clk) begin
        if (!reset_n) begin
            cnt_in_r   <= 1'b0;
            cap_prev_r <= 4'h0;
        end else begin
            cnt_in_r   <= ext_lvl;
            cap_prev_r <= pin_eff;
        end
    end

    // [R18] filter sample timer, period register holds the count minus one
    always @(posedge clk) begin
        if (!reset_n) begin
            filt_div_r <= 16'h0000;
        end else if (filt_sample) begin
            filt_div_r <= 16'h0000;
        end else begin
            filt_div_r <= filt_div_r + 16'h0001;
        end
    end

    // channel counter; a software preload wins over a same-cycle clear or tick
    always @(posedge clk) begin
        if (!reset_n) begin
            channel_counter_r <= 16'h0000;
        end else if (wr_en && (addr == `OFS_COUNTER)) begin
            channel_counter_r <= wdata[15:0];
        end else if (clr_hit) begin
            // [R19] clear after the capture has taken the old value
            channel_counter_r <= 16'h0000;
        end else if (counting && tick) begin
            // [R1] count on the selected tick
            channel_counter_r <= channel_counter_r + 16'h0001;
        end
    end

    // converter start, one cycle after the register A event
    always @(posedge clk) begin
        if (!reset_n) begin
            adc_trigger <= 1'b0;
        end else begin
            // [R14] A/D start on register A event
            adc_trigger <= HAS_ADC && clk_ctrl_r[`CC_ADC_BIT] && cap_ev[0];
        end
    end

    // read data stand for the one cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (!reset_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr)
                `OFS_CLK_CTRL:  rdata <= clk_ctrl_r;
                `OFS_CAP_CTRL:  rdata <= cap_ctrl_r;
                `OFS_STATUS:    rdata <= status_word;
                `OFS_COUNTER:   rdata <= {16'h0000, channel_counter_r};
                `OFS_CAP_A:     rdata <= {16'h0000, cap_val[0]};
                `OFS_CAP_B:     rdata <= {16'h0000, cap_val[1]};
                `OFS_CAP_C:     rdata <= {16'h0000, cap_val[2]};
                `OFS_CAP_D:     rdata <= {16'h0000, cap_val[3]};
                `OFS_FILT_CTRL: rdata <= {16'h0000, filt_ctrl_r};
                default:        rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule

// >>> verif/pin_source.sv
// far-side pin model: bursts of five pulses on one count-clock pin, capture levels
// assumes requests at the rising edge of clk and one burst at a time
`timescale 1ns/1ps
module pin_source (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       go,
    input  wire [1:0] sel,
    input  wire [3:0] cap_req,
    output reg  [3:0] ext_clk,
    output reg  [3:0] cap_pin,
    output wire       busy
);
    reg [3:0] halves_r;
    reg [1:0] ph_r;
    assign busy = |halves_r;
    always @(posedge clk) begin
        cap_pin <= cap_req;
        if (!reset_n) begin
            halves_r <= 4'h0;
            ext_clk  <= 4'h0;
        end else if (go) begin
            halves_r <= 4'ha;
            ph_r     <= 2'h0;
        end else if (busy) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h2) begin
                ph_r         <= 2'h0;
                halves_r     <= halves_r - 4'h1;
                ext_clk[sel] <= ~ext_clk[sel];
            end
        end
    end
endmodule

// >>> verif/capture_channel_checker.sv
// port assertions for the input-capture channel
// assumes it is bound to the channel and shadows the control writes itself
`timescale 1ns/1ps
`include "capture_channel_regs.vh"
module capture_channel_checker (
    input wire        clk,
    input wire        reset_n,
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire [31:0] rdata,
    input wire [3:0]  capture_irq,
    input wire        adc_trigger,
    input wire        underflow,
    input wire        clear_out
);
    reg  [31:0] ctl_r;
    reg  [2:0]  clr_r;
    reg         adc_r;
    wire [3:0]  irq_en = {ctl_r[25], ctl_r[17], ctl_r[9], ctl_r[1]};
    wire        flag_wr = wr_en && addr == `OFS_STATUS && wdata[0];
    always @(posedge clk) begin
        if (!reset_n) begin
            ctl_r <= 32'h0000_0000;
            clr_r <= 3'h0;
            adc_r <= 1'b0;
        end else if (wr_en && addr == `OFS_CAP_CTRL) begin
            ctl_r <= wdata & 32'h3f3f_3f3f;
        end else if (wr_en && addr == `OFS_CLK_CTRL) begin
            clr_r <= wdata[14:12];
            adc_r <= wdata[17];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_ctl_read;
        rd_en && addr == `OFS_CAP_CTRL;
    endsequence
    sequence s_flag_kept;
        capture_irq[0] && !flag_wr;
    endsequence
    a_rdata_idle: assert property (!rd_en |=> rdata == 32'h0)
        else $error("read data outside a read cycle");
    a_ctl_readback: assert property (s_ctl_read |=> rdata == $past(ctl_r))
        else $error("capture control read back wrong");
    a_underflow_low: assert property (underflow == 1'b0)
        else $error("underflow on an up counter");
    a_irq_masked: assert property ((capture_irq & ~irq_en) == 4'h0)
        else $error("interrupt without enable");
    a_flag_kept: assert property (s_flag_kept |=> capture_irq[0] || !irq_en[0])
        else $error("capture flag lost without clear");
    a_adc_gate: assert property (adc_trigger |-> $past(adc_r))
        else $error("converter start while disabled");
    a_clear_src: assert property (clear_out |-> clr_r < 3'h4)
        else $error("capture clear with other clear source");
    a_clear_en: assert property (clear_out |-> ctl_r[clr_r[1:0] * 8])
        else $error("capture clear with capture off");
endmodule

// >>> verif/testbench.sv
// self-checking bench for the input-capture channel, channel 0
// assumes the pin model drives count-clock and capture pins
`timescale 1ns/1ps
`include "capture_channel_regs.vh"
module testbench;
    reg         clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    reg         sync_clear_in = 1'b0, go = 1'b0, adc_seen = 1'b0;
    reg  [1:0]  sel = 2'h0;
    reg  [3:0]  cap_req = 4'h0;
    reg  [7:0]  addr = 8'h00;
    reg  [31:0] wdata = 32'h0000_0000, r, c0, v;
    wire [31:0] rdata;
    wire [3:0]  ext_clk, capture_input_pin, capture_irq;
    wire        adc_trigger, busy;
    integer     err_total = 0, cmp_count = 0, i, e;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (adc_trigger) adc_seen <= 1'b1;
    timer_input_capture_channel timer_input_capture_channel_inst (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ext_count_clock_a(ext_clk[0]),
        .ext_count_clock_b(ext_clk[1]), .ext_count_clock_c(ext_clk[2]),
        .ext_count_clock_d(ext_clk[3]), .cascade_ovf(1'b0), .cascade_unf(1'b0),
        .sync_clear_in(sync_clear_in), .capture_input_pin(capture_input_pin),
        .capture_irq(capture_irq), .adc_trigger(adc_trigger), .overflow(),
        .underflow(), .clear_out());
    pin_source pin_source_inst (.clk(clk), .reset_n(reset_n), .go(go), .sel(sel),
        .cap_req(cap_req), .ext_clk(ext_clk), .cap_pin(capture_input_pin), .busy(busy));
    task final_report;
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] x);
        cmp_count = cmp_count + 1;
        if (g !== x) begin
            err_total = err_total + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
        @(posedge clk) wr_en <= 1'b0;
    endtask
    task rd(input [7:0] a, output [31:0] d);
        @(posedge clk) begin addr <= a; rd_en <= 1'b1; end
        @(posedge clk) rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task cap(input [3:0] lv);
        @(posedge clk) cap_req <= lv;
        repeat (30) @(posedge clk);
    endtask
    task st(input [3:0] f);
        rd(`OFS_STATUS, r);
        chk(r[3:0], f);
    endtask
    task burst(input [1:0] s);
        integer n;
        @(posedge clk) begin sel <= s; go <= 1'b1; end
        @(posedge clk) go <= 1'b0;
        n = 0;
        #1 while (busy && n < 500) begin @(posedge clk); #1 n = n + 1; end
        if (n >= 500) begin err_total = err_total + 1; final_report; end
    endtask
    function [31:0] rst_val(input [7:0] a);
        rst_val = a == `OFS_CLK_CTRL ? `CLK_CTRL_RST : a == `OFS_FILT_CTRL ? 32'h3 : 32'h0;
    endfunction
    function integer dv(input integer k);
        dv = k < 7 ? 1 << k : k == 7 ? 256 : 1024;
    endfunction
    initial begin
        v = $urandom(34650);
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        wr(8'h24, $urandom);
        for (i = 0; i < 10; i++) begin rd(i * 4, r); chk(r, rst_val(i * 4)); end
        for (i = 0; i < 9; i++) begin
            wr(`OFS_CLK_CTRL, 32'h0001_5005 | i << 8 | ($urandom % 3) << 4);
            rd(`OFS_COUNTER, c0);
            repeat (2 * dv(i) - 2) @(posedge clk);
            rd(`OFS_COUNTER, r);
            chk((r - c0) & 32'hffff, 2);
        end
        for (i = 0; i < 4; i++) for (e = 0; e < 3; e++) begin
            wr(`OFS_CLK_CTRL, 32'h0001_5300 | i | e << 4);
            rd(`OFS_COUNTER, c0);
            burst(i);
            repeat (6) @(posedge clk);
            rd(`OFS_COUNTER, r);
            chk((r - c0) & 32'hffff, e == 2 ? 10 : 5);
        end
        wr(`OFS_CLK_CTRL, 32'h0001_5005);
        for (e = 0; e < 3; e++) begin
            wr(`OFS_CAP_CTRL, 32'h0000_0207 | e << 4);
            cap(4'h0);
            wr(`OFS_STATUS, 32'hf);
            cap(4'h3);
            st(e != 1);
            chk(capture_irq, e != 1);
            wr(`OFS_STATUS, 32'hf);
            cap(4'h0);
            st(e != 0);
        end
        wr(`OFS_CLK_CTRL, 32'h0001_0005);
        wr(`OFS_CAP_CTRL, 32'h7);
        v = $urandom % 32'h7000 + 32'h8000;
        wr(`OFS_COUNTER, v);
        cap(4'h1);
        rd(`OFS_CAP_A, r);
        chk(r >= v && r < v + 48, 1);
        rd(`OFS_COUNTER, r);
        chk(r < 48, 1);
        wr(`OFS_CLK_CTRL, 32'h0001_4005);
        wr(`OFS_COUNTER, v);
        @(posedge clk) sync_clear_in <= 1'b1;
        @(posedge clk) sync_clear_in <= 1'b0;
        rd(`OFS_COUNTER, r);
        chk(r < 8, 1);
        wr(`OFS_CLK_CTRL, 32'h0001_5005);
        wr(`OFS_CAP_CTRL, 32'h2f);
        cap(4'h0);
        wr(`OFS_STATUS, 32'hf);
        cap_req <= 4'h1;
        cap(4'h0);
        st(0);
        cap(4'h1);
        st(1);
        wr(`OFS_CLK_CTRL, 32'h0003_5005);
        wr(`OFS_CAP_CTRL, 32'h3);
        rd(`OFS_CAP_CTRL, r);
        chk(r, 32'h3);
        cap(4'h0);
        wr(`OFS_STATUS, 32'hf);
        adc_seen = 1'b0;
        cap(4'h1);
        chk(adc_seen, 1);
        wr(`OFS_STATUS, 32'h1);
        rd(`OFS_STATUS, r);
        chk(r[8], 0);
        rd(`OFS_COUNTER, c0);
        rd(`OFS_COUNTER, r);
        chk(r, c0);
        wr(`OFS_CLK_CTRL, 32'h0003_5005);
        rd(`OFS_STATUS, r);
        chk(r[8], 1);
        final_report;
    end
endmodule
bind timer_input_capture_channel capture_channel_checker capture_channel_checker_inst (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .capture_irq(capture_irq), .adc_trigger(adc_trigger),
    .underflow(underflow), .clear_out(clear_out));
